//--- hdl/dgp_params.svh
// Offsets, field positions, reset values and pin-function codes for the dual GPIO data ports
`ifndef DGP_PARAMS_SVH
`define DGP_PARAMS_SVH

// ============================================================
// Register offsets (byte addresses, one aligned word each)
`define DGP_OFF_FIRST_DATA   4'h0
`define DGP_OFF_SECOND_DATA  4'h4
`define DGP_OFF_CODE_STATUS  4'h8
`define DGP_OFF_PIN_LEVEL    4'hC
`define DGP_ADR_W            4

// ============================================================
// Widths and reset values
`define DGP_PORT_W           16
`define DGP_DATA_RESET       16'h0000
`define DGP_LO_BYTE_W        8

// Bits 7 and 6 of the second port read back but ignore writes
`define DGP_SECOND_WR_MASK   16'hFF3F

// ============================================================
// Two-bit pin function codes, high bit first
`define DGP_CODE_INPUT       2'h0
`define DGP_CODE_OUTPUT      2'h1
`define DGP_CODE_RESERVED    2'h2
`define DGP_CODE_OTHER       2'h3

`endif

//--- hdl/dgp_pkg.sv
// Types shared by the dual GPIO data port design
package dgp_pkg;
  typedef logic [15:0] dgp_word_t;
  typedef logic [31:0] dgp_codes_t;
  typedef logic [1:0]  dgp_code_t;
  typedef logic [31:0] dgp_bus_t;
endpackage

//--- hdl/dgp_port.sv
// Per-pin function decode for one 16-bit port: read source, drive enable, reserved-code flag
`timescale 1ns/1ns
`include "dgp_params.svh"
module dgp_port #(
  parameter bit LO_IN_OUT_ONLY = 1'b0
) (
  input  wire dgp_pkg::dgp_word_t  stored_i,
  input  wire dgp_pkg::dgp_word_t  pins_i,
  input  wire dgp_pkg::dgp_codes_t func_i,
  output dgp_pkg::dgp_word_t       rd_o,
  output dgp_pkg::dgp_word_t       drive_o,
  output dgp_pkg::dgp_word_t       bad_o
);

  for (genvar n = 0; n < `DGP_PORT_W; n++) begin : g_pin
    dgp_pkg::dgp_code_t code;
    logic               restricted;
    assign code       = func_i[2*n+1 -: 2];
    assign restricted = LO_IN_OUT_ONLY && (n < `DGP_LO_BYTE_W);

    // Only the output code drives; input, other function and reserved read the pin
    assign drive_o[n] = (code == `DGP_CODE_OUTPUT);
    assign rd_o[n]    = drive_o[n] ? stored_i[n] : pins_i[n];
    // Reserved codes fall back to input behaviour and are flagged for software
    assign bad_o[n]   = restricted ? code[1] : (code == `DGP_CODE_RESERVED);
  end

endmodule

//--- hdl/dgp_sync.sv
// Three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/1ns
module dgp_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // Only stage2 and stage3 are compared; meta feeds stage2 alone
  always_comb begin
    next_level = level_o;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta    <= '0;
      stage2  <= '0;
      stage3  <= '0;
      level_o <= '0;
    end else begin
      meta    <= async_i;
      stage2  <= meta;
      stage3  <= stage2;
      level_o <= next_level;
    end
  end

endmodule

//--- hdl/dgp_top.sv
// Dual GPIO data ports with a classic Wishbone register slave
// Functional notes
// - First port: 16-bit read/write data register, one bit per pin, reset to zero.
// - Second port: 16-bit data register, one bit per pin, reset to zero.
// - Manual reset, standby and sleep leave both data registers unchanged.
// - First port code 00: read gives pin level, write stores only.
// - First port code 01: write stores and drives pin, read gives stored bit.
// - First port code 11 reads pin, writes store only; code 10 reserved.
// - Second port upper byte behaves as first port; code 10 reserved.
// - Second port lower byte code 01: write stores and drives, read stored; here bits 7 and 6 ignore writes.
// - Second port lower byte code 00 reads pin; other codes reserved.
`timescale 1ns/1ns
`include "dgp_params.svh"
module dgp_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Function codes from the pin function controller, two bits per pin
  input  wire dgp_pkg::dgp_codes_t   first_port_control_i,
  input  wire dgp_pkg::dgp_codes_t   second_port_control_i,
  // Pins
  input  wire dgp_pkg::dgp_word_t    first_port_pin_i,
  output dgp_pkg::dgp_word_t         first_port_pin_o,
  output dgp_pkg::dgp_word_t         first_port_pin_oe_o,
  input  wire dgp_pkg::dgp_word_t    second_port_pin_i,
  output dgp_pkg::dgp_word_t         second_port_pin_o,
  output dgp_pkg::dgp_word_t         second_port_pin_oe_o
);

  // ============================================================
  // Pin sampling
  dgp_pkg::dgp_word_t first_level;
  dgp_pkg::dgp_word_t second_level;

  // Pins come from outside the clock domain, so the sampled level lags a pin change by four edges
  dgp_sync #(
    .W (`DGP_PORT_W)
  ) u_first_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (first_port_pin_i),
    .level_o (first_level)
  );

  dgp_sync #(
    .W (`DGP_PORT_W)
  ) u_second_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (second_port_pin_i),
    .level_o (second_level)
  );

  // ============================================================
  // Function decode
  dgp_pkg::dgp_word_t first_port_data;
  dgp_pkg::dgp_word_t second_port_data;
  dgp_pkg::dgp_word_t first_rd;
  dgp_pkg::dgp_word_t second_rd;
  dgp_pkg::dgp_word_t first_drive;
  dgp_pkg::dgp_word_t second_drive;
  dgp_pkg::dgp_word_t first_bad;
  dgp_pkg::dgp_word_t second_bad;

  // Codes are used live from the controller and never stored here
  dgp_port #(
    .LO_IN_OUT_ONLY (1'b0)
  ) u_first_port (
    .stored_i (first_port_data),
    .pins_i   (first_level),
    .func_i   (first_port_control_i),
    .rd_o     (first_rd),
    .drive_o  (first_drive),
    .bad_o    (first_bad)
  );

  dgp_port #(
    .LO_IN_OUT_ONLY (1'b1)
  ) u_second_port (
    .stored_i (second_port_data),
    .pins_i   (second_level),
    .func_i   (second_port_control_i),
    .rd_o     (second_rd),
    .drive_o  (second_drive),
    .bad_o    (second_bad)
  );

  // ============================================================
  // Bus slave
  logic        req;
  logic        wr_now;
  logic [15:0] lane_mask;
  logic        next_ack;
  logic [31:0] next_dat;

  assign req       = wb_cyc_i && wb_stb_i;
  // A write commits on the edge where the master sees ack high
  assign wr_now    = req && wb_we_i && wb_ack_o;
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    next_ack = req && !wb_ack_o;
    next_dat = 32'h00000000;
    if (req && !wb_ack_o && !wb_we_i) begin
      unique case (wb_adr_i)
        `DGP_OFF_FIRST_DATA:  next_dat = {16'h0000, first_rd};
        `DGP_OFF_SECOND_DATA: next_dat = {16'h0000, second_rd};
        `DGP_OFF_CODE_STATUS: next_dat = {second_bad, first_bad};
        `DGP_OFF_PIN_LEVEL:   next_dat = {second_level, first_level};
        default:              next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ============================================================
  // Data registers and pin drivers
  dgp_pkg::dgp_word_t next_first;
  dgp_pkg::dgp_word_t next_second;
  dgp_pkg::dgp_word_t next_first_oe;
  dgp_pkg::dgp_word_t next_second_oe;
  dgp_pkg::dgp_word_t second_wr_mask;

  assign second_wr_mask = lane_mask & `DGP_SECOND_WR_MASK;

  // Writes land in the store whatever the pin function, except bits 7 and 6 of the second port
  always_comb begin
    next_first     = first_port_data;
    next_second    = second_port_data;
    next_first_oe  = first_drive;
    next_second_oe = second_drive;
    if (wr_now && (wb_adr_i == `DGP_OFF_FIRST_DATA)) begin
      next_first = (first_port_data & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
    end
    if (wr_now && (wb_adr_i == `DGP_OFF_SECOND_DATA)) begin
      next_second = (second_port_data & ~second_wr_mask)
                  | (wb_dat_i[15:0] & second_wr_mask);
    end
  end

  // Only the power-on reset clears the store; no other reset or low-power state reaches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_port_data      <= `DGP_DATA_RESET;
      second_port_data     <= `DGP_DATA_RESET;
      first_port_pin_oe_o  <= 16'h0000;
      second_port_pin_oe_o <= 16'h0000;
    end else begin
      first_port_data      <= next_first;
      second_port_data     <= next_second;
      first_port_pin_oe_o  <= next_first_oe;
      second_port_pin_oe_o <= next_second_oe;
    end
  end

  // Pin values mirror the store; the enable alone decides whether they reach the pad
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_port_pin_o  <= `DGP_DATA_RESET;
      second_port_pin_o <= `DGP_DATA_RESET;
    end else begin
      first_port_pin_o  <= next_first;
      second_port_pin_o <= next_second;
    end
  end

endmodule

//--- test/dgp_checker.sv
// Port-level assertions for the dual GPIO data ports
`timescale 1ns/1ns
module dgp_checker (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [3:0]          wb_adr_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire dgp_pkg::dgp_codes_t first_port_control_i,
  input wire dgp_pkg::dgp_codes_t second_port_control_i,
  input wire dgp_pkg::dgp_word_t  first_port_pin_o,
  input wire dgp_pkg::dgp_word_t  first_port_pin_oe_o,
  input wire dgp_pkg::dgp_word_t  second_port_pin_o,
  input wire dgp_pkg::dgp_word_t  second_port_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ============================================================
  // Bus sequences
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr0;
    s_req ##0 (wb_we_i && wb_adr_i == 4'h0);
  endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data idle");
  property p_wr; s_wr0 |-> ##2 first_port_pin_o == $past(wb_dat_i[15:0], 2); endproperty
  a_wr: assert property (p_wr) else $error("store");
  property p_keep;
    !(wb_ack_o && wb_we_i) |=> $stable(first_port_pin_o) && $stable(second_port_pin_o);
  endproperty
  a_keep: assert property (p_keep) else $error("store moved");
  property p_oe1; first_port_pin_oe_o[0] == ($past(first_port_control_i[1:0]) == 2'h1); endproperty
  a_oe1: assert property (p_oe1) else $error("oe1");
  property p_oe2h; second_port_pin_oe_o[15] == ($past(second_port_control_i[31:30]) == 2'h1); endproperty
  a_oe2h: assert property (p_oe2h) else $error("oe2h");
  property p_oe2l; second_port_pin_oe_o[0] == ($past(second_port_control_i[1:0]) == 2'h1); endproperty
  a_oe2l: assert property (p_oe2l) else $error("oe2l");
endmodule

//--- test/dgp_pins.sv
// Outside world of one port: driven pins show the port, others the outside level
`timescale 1ns/1ns
module dgp_pins (
  input  wire dgp_pkg::dgp_word_t pin_i,
  input  wire dgp_pkg::dgp_word_t oe_i,
  input  wire dgp_pkg::dgp_word_t ext_i,
  output dgp_pkg::dgp_word_t      level_o
);
  assign level_o = (oe_i & pin_i) | (~oe_i & ext_i);
endmodule

//--- test/dgp_top_test.sv
// Self-checking bench for the dual GPIO data ports
`timescale 1ns/1ns
module dgp_top_test;
  logic               clk_i;
  logic               rst_i;
  logic               cyc;
  logic               we;
  logic [3:0]         adr;
  logic [31:0]        wdat;
  logic [31:0]        rdat;
  logic [31:0]        q;
  logic               ack;
  dgp_pkg::dgp_codes_t c1;
  dgp_pkg::dgp_codes_t c2;
  dgp_pkg::dgp_word_t e1, e2, l1, l2, p1, p2, o1, o2;
  int                 fail_count;
  int                 num_checks;
  dgp_top DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .first_port_control_i(c1), .second_port_control_i(c2), .first_port_pin_i(l1),
    .first_port_pin_o(p1), .first_port_pin_oe_o(o1), .second_port_pin_i(l2),
    .second_port_pin_o(p2), .second_port_pin_oe_o(o2));
  dgp_pins u_pa (.pin_i(p1), .oe_i(o1), .ext_i(e1), .level_o(l1));
  dgp_pins u_pb (.pin_i(p2), .oe_i(o2), .ext_i(e2), .level_o(l2));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // Waits for ack without a limit of its own; the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Reserved code 10 is never selected by this stimulus
  task automatic t_first();
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    c1 <= 32'h55555555;
    bus(1'b1, 4'h0, 32'hA5C3);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'hA5C3);
    chk({o1, l1}, 32'hFFFFA5C3);
    c1 <= 32'h0;
    e1 <= 16'h3C69;
    repeat (6) @(posedge clk_i);
    bus(1'b1, 4'h0, 32'h1111);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h3C69);
    chk({o1, l1}, 32'h00003C69);
    c1 <= 32'hFFFFFFFF;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h3C69);
    c1 <= 32'h55555555;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h1111);
    $display("first port done");
  endtask
  task automatic t_second();
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    c2 <= 32'h55555555;
    bus(1'b1, 4'h4, 32'hFFFF);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'hFF3F);
    chk(l2, 32'hFF3F);
    c2 <= 32'hFFFF0000;
    e2 <= 16'h1234;
    repeat (6) @(posedge clk_i);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h1234);
    chk({o2, p2}, 32'hFF3F);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h12341111);
    $display("second port done");
  endtask
  initial begin
    {rst_i, cyc, we, adr, wdat, c1, c2, e1, e2} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_first();
    t_second();
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
endmodule
bind dgp_top dgp_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .first_port_control_i, .second_port_control_i,
  .first_port_pin_o, .first_port_pin_oe_o, .second_port_pin_o, .second_port_pin_oe_o);
